/* hdl/sst_pkg.sv */
// Package: constants and types of the safe stop trip handler
package sst_pkg;
   // =====================================================
   // Register map (word offsets on the plain port)
   localparam logic [3:0] ADDR_MODE = 4'h0;
   localparam logic [3:0] ADDR_CTRL = 4'h1;
   localparam logic [3:0] ADDR_STATUS = 4'h2;
   localparam logic [3:0] ADDR_EVENT = 4'h3;
   // =====================================================
   // Mode values
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_STOP_ALARM = 4'h1;
   localparam logic [3:0] MODE_STOP_WARN = 4'h3;
   localparam logic [3:0] MODE_THERM_ALARM = 4'h4;
   localparam logic [3:0] MODE_THERM_WARN = 4'h5;
   localparam logic [3:0] MODE_BOTH_ALARM = 4'h6;
   localparam logic [3:0] MODE_BOTH_WARN = 4'h7;
   localparam logic [3:0] MODE_THERM_A_RELAY_W = 4'h8;
   localparam logic [3:0] MODE_THERM_W_RELAY_A = 4'h9;
   localparam logic [3:0] MODE_RESET = MODE_STOP_ALARM;
   // =====================================================
   // Event codes
   localparam logic [7:0] CODE_NONE = 8'h00;
   localparam logic [7:0] CODE_RELAY = 8'h44;
   localparam logic [7:0] CODE_THERM = 8'h47;
   localparam logic [7:0] CODE_DANGER = 8'h48;
   // =====================================================
   // Status and control fields
   localparam int ST_COAST = 0;
   localparam int ST_LATCH = 1;
   localparam int ST_ALARM = 2;
   localparam int ST_WARN = 3;
   localparam int ST_THERM = 4;
   localparam int ST_RELAY = 5;
   localparam int ST_DANGER = 6;
   localparam int ST_REFUSED = 7;
   localparam int CTRL_RESET = 0;
   localparam int CTRL_DANGER_CLR = 1;
   // Synchroniser reset level for active-low pins
   localparam logic SYNC_IDLE_N = 1'b1;
   typedef enum logic [1:0] {
      SST_RUN,
      SST_WARN,
      SST_LATCH
   } sst_state_t;
endpackage

/* hdl/sst_sync.sv */
// Two-flop synchroniser for a pin level
`timescale 1ns/1ns
module sst_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic d,
   output logic q
);
   logic meta;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= RST_VAL;
         q <= RST_VAL;
      end else if (ce) begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

/* hdl/sst_top.sv */
// Safe stop supervision: coasting, latching, reset and event report
`timescale 1ns/1ns
module sst_top (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic SAFE_STOP_N,
   input wire logic THERMISTOR_TRIP_INDICATOR_N,
   input wire logic CARD_PRESENT,
   input wire logic DANGER_FAULT,
   input wire logic RESET_REQ,
   input wire logic [3:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   output logic COAST,
   output logic ALARM,
   output logic WARNING,
   output logic [7:0] EVENT_CODE
);
   // =====================================================
   // Pin synchronisation
   logic stop_s_n;
   logic trip_s_n;
   logic card_s;
   logic danger_s;
   logic reset_s;
   logic reset_d;
   // Active-low pins reset to idle, else a false stop latches after reset
   sst_sync #(.RST_VAL(sst_pkg::SYNC_IDLE_N)) u_stop (.clk(CORE_CLK),
      .rst_n(RST_N), .ce(CE), .d(SAFE_STOP_N), .q(stop_s_n));
   sst_sync #(.RST_VAL(sst_pkg::SYNC_IDLE_N)) u_trip (.clk(CORE_CLK),
      .rst_n(RST_N), .ce(CE), .d(THERMISTOR_TRIP_INDICATOR_N),
      .q(trip_s_n));
   sst_sync u_card (.clk(CORE_CLK), .rst_n(RST_N), .ce(CE),
      .d(CARD_PRESENT), .q(card_s));
   sst_sync u_dang (.clk(CORE_CLK), .rst_n(RST_N), .ce(CE),
      .d(DANGER_FAULT), .q(danger_s));
   sst_sync u_rst (.clk(CORE_CLK), .rst_n(RST_N), .ce(CE),
      .d(RESET_REQ), .q(reset_s));

   logic stop_act;
   logic trip_act;
   assign stop_act = ~stop_s_n;
   assign trip_act = ~trip_s_n;

   // =====================================================
   // Registers
   logic [3:0] mode;
   logic refused;
   logic sw_reset;
   logic danger_clr;
   logic reset_pulse;
   logic mode_ok;
   logic wr_mode;

   assign wr_mode = WR && (ADDR == sst_pkg::ADDR_MODE);
   always_comb begin
      case (WDATA[3:0])
         sst_pkg::MODE_OFF,
         sst_pkg::MODE_STOP_ALARM,
         sst_pkg::MODE_STOP_WARN: mode_ok = 1'b1;
         sst_pkg::MODE_THERM_ALARM,
         sst_pkg::MODE_THERM_WARN,
         sst_pkg::MODE_BOTH_ALARM,
         sst_pkg::MODE_BOTH_WARN,
         sst_pkg::MODE_THERM_A_RELAY_W,
         sst_pkg::MODE_THERM_W_RELAY_A: mode_ok = card_s;
         default: mode_ok = 1'b0;
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         mode <= sst_pkg::MODE_RESET;
         refused <= 1'b0;
      end else if (CE && wr_mode) begin
         if (mode_ok) begin
            mode <= WDATA[3:0];
         end
         refused <= ~mode_ok;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sw_reset <= 1'b0;
         danger_clr <= 1'b0;
         reset_d <= 1'b0;
      end else if (CE) begin
         sw_reset <= WR && (ADDR == sst_pkg::ADDR_CTRL) &&
            WDATA[sst_pkg::CTRL_RESET];
         danger_clr <= WR && (ADDR == sst_pkg::ADDR_CTRL) &&
            WDATA[sst_pkg::CTRL_DANGER_CLR];
         reset_d <= reset_s;
      end
   end
   // Pin reset acts on its rising edge only, so a held button cannot loop
   assign reset_pulse = sw_reset | (reset_s & ~reset_d);

   // =====================================================
   // Per-source handling
   logic therm_used;
   logic therm_alarm;
   logic relay_alarm;
   always_comb begin
      therm_used = 1'b1;
      therm_alarm = 1'b1;
      relay_alarm = 1'b1;
      case (mode)
         sst_pkg::MODE_STOP_WARN: begin
            therm_used = 1'b0;
            relay_alarm = 1'b0;
         end
         sst_pkg::MODE_THERM_WARN,
         sst_pkg::MODE_BOTH_WARN: begin
            therm_alarm = 1'b0;
            relay_alarm = 1'b0;
         end
         sst_pkg::MODE_THERM_A_RELAY_W: relay_alarm = 1'b0;
         sst_pkg::MODE_THERM_W_RELAY_A: therm_alarm = 1'b0;
         sst_pkg::MODE_THERM_ALARM,
         sst_pkg::MODE_BOTH_ALARM: therm_used = 1'b1;
         sst_pkg::MODE_OFF,
         sst_pkg::MODE_STOP_ALARM: therm_used = 1'b0;
         default: therm_used = 1'b0;
      endcase
   end

   // Source attribution: trip input present in a card mode (4 to 9) means the card caused it
   logic src_therm;
   logic alarm_src;
   logic active;
   assign active = (mode != sst_pkg::MODE_OFF) & stop_act;
   assign src_therm = therm_used & trip_act;
   assign alarm_src = src_therm ? therm_alarm : relay_alarm;

   // =====================================================
   // Stop state machine
   sst_pkg::sst_state_t state;
   sst_pkg::sst_state_t next_state;
   logic clear_ok;
   logic latched_therm;
   assign clear_ok = ~stop_act & ~trip_act;

   always_comb begin
      case (state)
         sst_pkg::SST_RUN: begin
            if (active && alarm_src) begin
               next_state = sst_pkg::SST_LATCH;
            end else if (active) begin
               next_state = sst_pkg::SST_WARN;
            end else begin
               next_state = sst_pkg::SST_RUN;
            end
         end
         sst_pkg::SST_WARN: begin
            if (active && alarm_src) begin
               next_state = sst_pkg::SST_LATCH;
            end else if (clear_ok) begin
               next_state = sst_pkg::SST_RUN;
            end else begin
               next_state = sst_pkg::SST_WARN;
            end
         end
         sst_pkg::SST_LATCH: begin
            // Only a manual reset leaves; no automatic path
            if (reset_pulse && clear_ok) begin
               next_state = sst_pkg::SST_RUN;
            end else begin
               next_state = sst_pkg::SST_LATCH;
            end
         end
         default: next_state = sst_pkg::SST_LATCH;
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= sst_pkg::SST_RUN;
      end else if (CE) begin
         state <= next_state;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         latched_therm <= 1'b0;
      end else if (CE && active) begin
         latched_therm <= src_therm;
      end
   end

   // =====================================================
   // Dangerous failure flag: set wins over clear
   logic danger;
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         danger <= 1'b0;
      end else if (CE) begin
         if (danger_s) begin
            danger <= 1'b1;
         end else if (danger_clr && clear_ok) begin
            danger <= 1'b0;
         end
      end
   end

   // =====================================================
   // Outputs
   logic next_coast;
   logic next_alarm;
   logic next_warn;
   logic [7:0] next_code;
   assign next_coast = (next_state != sst_pkg::SST_RUN) | danger_s | danger;
   assign next_alarm = (next_state == sst_pkg::SST_LATCH) | danger_s |
      danger;
   assign next_warn = next_state == sst_pkg::SST_WARN;
   always_comb begin
      if (danger_s || danger) begin
         next_code = sst_pkg::CODE_DANGER;
      end else if (next_state == sst_pkg::SST_RUN) begin
         next_code = sst_pkg::CODE_NONE;
      end else if (active ? src_therm : latched_therm) begin
         next_code = sst_pkg::CODE_THERM;
      end else begin
         next_code = sst_pkg::CODE_RELAY;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         COAST <= 1'b0;
         ALARM <= 1'b0;
         WARNING <= 1'b0;
         EVENT_CODE <= sst_pkg::CODE_NONE;
      end else if (CE) begin
         COAST <= next_coast;
         ALARM <= next_alarm;
         WARNING <= next_warn;
         EVENT_CODE <= next_code;
      end
   end

   // =====================================================
   // Read port, data one cycle after the strobe
   logic [7:0] status;
   always_comb begin
      status = 8'h00;
      status[sst_pkg::ST_COAST] = COAST;
      status[sst_pkg::ST_LATCH] = state == sst_pkg::SST_LATCH;
      status[sst_pkg::ST_ALARM] = ALARM;
      status[sst_pkg::ST_WARN] = WARNING;
      status[sst_pkg::ST_THERM] = trip_act;
      status[sst_pkg::ST_RELAY] = stop_act;
      status[sst_pkg::ST_DANGER] = danger;
      status[sst_pkg::ST_REFUSED] = refused;
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         RDATA <= 32'h0000_0000;
      end else if (CE) begin
         if (RD) begin
            case (ADDR)
               sst_pkg::ADDR_MODE: RDATA <= {28'h0000000, mode};
               sst_pkg::ADDR_STATUS: RDATA <= {24'h000000, status};
               sst_pkg::ADDR_EVENT: RDATA <= {24'h000000, EVENT_CODE};
               default: RDATA <= 32'h0000_0000;
            endcase
         end else begin
            RDATA <= 32'h0000_0000;
         end
      end
   end

   // =====================================================
   // Checks
   sequence s_latched;
      state == sst_pkg::SST_LATCH;
   endsequence

   a_latch_holds: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      s_latched and (CE && !reset_pulse) |=> state == sst_pkg::SST_LATCH)
      else $error("Latch left without reset");
   a_reset_needs_clear: assert property (@(posedge CORE_CLK)
      disable iff (!RST_N)
      s_latched and (CE && reset_pulse && !clear_ok) |=> s_latched)
      else $error("Reset released with input active");
   a_warn_holds: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      CE && state == sst_pkg::SST_WARN && trip_act
      |=> state != sst_pkg::SST_RUN)
      else $error("Warning ended with trip active");
   a_coast_follows: assert property (@(posedge CORE_CLK)
      disable iff (!RST_N)
      CE && state != sst_pkg::SST_RUN |-> COAST)
      else $error("Stopped state without coast");
   a_mode_refused: assert property (@(posedge CORE_CLK)
      disable iff (!RST_N)
      CE && wr_mode && !card_s && WDATA[3:0] >= sst_pkg::MODE_THERM_ALARM
      |=> $stable(mode) && refused)
      else $error("Card mode taken without card");
   a_danger_code: assert property (@(posedge CORE_CLK)
      disable iff (!RST_N)
      CE && danger |=> EVENT_CODE == sst_pkg::CODE_DANGER)
      else $error("Danger code missing");
   a_warn_resume: assert property (@(posedge CORE_CLK)
      disable iff (!RST_N)
      CE && state == sst_pkg::SST_WARN && clear_ok && !active
      |=> state == sst_pkg::SST_RUN)
      else $error("Warning did not auto resume");
   a_plain_warn: assert property (@(posedge CORE_CLK)
      disable iff (!RST_N)
      CE && mode == sst_pkg::MODE_STOP_WARN && state == sst_pkg::SST_RUN
      && active |=> state == sst_pkg::SST_WARN)
      else $error("Plain warning latched");
   a_therm_code: assert property (@(posedge CORE_CLK)
      disable iff (!RST_N)
      CE && !danger && !danger_s && next_state != sst_pkg::SST_RUN
      && active && src_therm |=> EVENT_CODE == sst_pkg::CODE_THERM)
      else $error("Thermistor code wrong");
endmodule

/* tb/sst_chain_model.sv */
// Thermistor card and safety relay chain driving the stop pins
`timescale 1ns/1ns
module sst_chain_model (
   input wire logic clk,
   input wire logic overtemp,
   input wire logic button,
   input wire logic slow_release,
   output logic stop_n,
   output logic trip_n
);
   // ==========================================
   // Series stop line
   // Card first in the chain, stop button behind the relay
   always_ff @(posedge clk) begin
      stop_n <= ~(overtemp | button);
   end
   // ==========================================
   // Trip indicator
   // Only this output feeds the trip input; it may lag on release
   always_ff @(posedge clk) begin
      trip_n <= ~(overtemp | (slow_release & ~trip_n));
   end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the safe stop trip handler
`timescale 1ns/1ns
module tb_top;
   // ==========================================
   // Signals
   logic CORE_CLK = 1'b0;
   logic RST_N = 1'b0;
   logic card = 1'b0;
   logic danger = 1'b0;
   logic rreq = 1'b0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic overtemp = 1'b0;
   logic button = 1'b0;
   logic slow = 1'b0;
   logic stop_n, trip_n, coast, alarm, warning;
   logic [31:0] rdata, rv;
   logic [7:0] code, c;
   logic [3:0] m;
   logic th, al;
   int n_fail = 0;
   int n_compared = 0;
   // Mode, thermistor source, alarm class, expected event code
   logic [13:0] cases [12] = '{{4'h1, 2'b01, 8'h44}, {4'h3, 2'b00, 8'h44},
      {4'h4, 2'b11, 8'h47}, {4'h5, 2'b10, 8'h47}, {4'h6, 2'b11, 8'h47},
      {4'h6, 2'b01, 8'h44}, {4'h7, 2'b10, 8'h47}, {4'h7, 2'b00, 8'h44},
      {4'h8, 2'b11, 8'h47}, {4'h8, 2'b00, 8'h44}, {4'h9, 2'b10, 8'h47},
      {4'h9, 2'b01, 8'h44}};
   always #10 CORE_CLK = ~CORE_CLK;
   sst_chain_model sst_chain_model_inst (.clk(CORE_CLK),
      .overtemp(overtemp), .button(button), .slow_release(slow),
      .stop_n(stop_n), .trip_n(trip_n));
   sst_top sst_top_inst (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CE(1'b1),
      .SAFE_STOP_N(stop_n), .THERMISTOR_TRIP_INDICATOR_N(trip_n),
      .CARD_PRESENT(card), .DANGER_FAULT(danger), .RESET_REQ(rreq),
      .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
      .COAST(coast), .ALARM(alarm), .WARNING(warning), .EVENT_CODE(code));
   // ==========================================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge CORE_CLK);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge CORE_CLK);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge CORE_CLK);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge CORE_CLK);
      rd_s <= 1'b0;
      @(negedge CORE_CLK);
      rv = rdata;
   endtask
   // Pins need two sync edges plus the output edge
   task automatic settle;
      repeat (4) @(posedge CORE_CLK);
      @(negedge CORE_CLK);
   endtask
   task automatic look(input logic ec, ea, ew, input logic [7:0] ex);
      settle;
      chk("coast", 32'(coast), 32'(ec));
      chk("alarm", 32'(alarm), 32'(ea));
      chk("warning", 32'(warning), 32'(ew));
      chk("event", 32'(code), 32'(ex));
   endtask
   // Pin reset acts on its rising edge, register reset on the write
   task automatic manual(input logic by_pin);
      if (by_pin) begin
         @(posedge CORE_CLK);
         rreq <= 1'b1;
         repeat (3) @(posedge CORE_CLK);
         rreq <= 1'b0;
      end else begin
         wr(sst_pkg::ADDR_CTRL, 32'h1);
      end
   endtask
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ==========================================
   // Sequence
   initial begin
      repeat (20) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      rd(sst_pkg::ADDR_MODE);
      chk("mode reset", rv, 32'h1);
      rd(4'hf);
      chk("unmapped", rv, 32'h0);
      rd(sst_pkg::ADDR_STATUS);
      chk("status reset", rv, 32'h0);
      wr(sst_pkg::ADDR_MODE, 32'h5);
      rd(sst_pkg::ADDR_MODE);
      chk("mode refused", rv, 32'h1);
      rd(sst_pkg::ADDR_STATUS);
      chk("refused flag", 32'(rv[7]), 32'h1);
      @(posedge CORE_CLK);
      card <= 1'b1;
      settle;
      $display("test reset and refusal done");
      for (int i = 0; i < 12; i++) begin
         {m, th, al, c} = cases[i];
         wr(sst_pkg::ADDR_MODE, {28'h0, m});
         rd(sst_pkg::ADDR_MODE);
         chk("mode", rv, {28'h0, m});
         @(posedge CORE_CLK);
         overtemp <= th;
         button <= ~th;
         slow <= th & ~al;
         look(1'b1, al, ~al, c);
         rd(sst_pkg::ADDR_STATUS);
         chk("status", rv[5:0], {1'b1, th, ~al, al, al, 1'b1});
         rd(sst_pkg::ADDR_EVENT);
         chk("event reg", rv, {24'h0, c});
         if (al) begin
            manual(i[0]);
            settle;
            chk("latch kept", 32'(alarm), 32'h1);
         end
         @(posedge CORE_CLK);
         overtemp <= 1'b0;
         button <= 1'b0;
         settle;
         chk("coast held", 32'(coast), 32'(al | th));
         @(posedge CORE_CLK);
         slow <= 1'b0;
         if (al) begin
            manual(i[0]);
         end
         look(1'b0, 1'b0, 1'b0, 8'h00);
         $display("test mode %0d source %0d done", m, th);
      end
      // Mode two is a hole in the map, refused even with the card fitted
      wr(sst_pkg::ADDR_MODE, 32'h2);
      rd(sst_pkg::ADDR_MODE);
      chk("mode two", rv, 32'h9);
      wr(sst_pkg::ADDR_MODE, 32'h0);
      rd(sst_pkg::ADDR_STATUS);
      chk("refused cleared", 32'(rv[7]), 32'h0);
      @(posedge CORE_CLK);
      button <= 1'b1;
      look(1'b0, 1'b0, 1'b0, 8'h00);
      @(posedge CORE_CLK);
      button <= 1'b0;
      settle;
      $display("test mode off done");
      // Danger has no release path but the explicit clear
      @(posedge CORE_CLK);
      danger <= 1'b1;
      settle;
      chk("danger alarm", 32'(alarm), 32'h1);
      chk("danger code", 32'(code), 32'h48);
      @(posedge CORE_CLK);
      danger <= 1'b0;
      wr(sst_pkg::ADDR_CTRL, 32'h2);
      settle;
      chk("danger clear", 32'(alarm), 32'h0);
      $display("test danger done");
      print_verdict;
   end
endmodule
